// *** dmc_decode.sv ***
// data-move command decoder with wishbone control and status registers
// assumes command pins and their link clock come from another clock
// domain; the link clock is sampled, never used as a clock
`timescale 1ns/1ps
`default_nettype none
// How it works
// - data-move commands take two link cycles, probes four, told by type bit
// - first cycle: code, victim/probe release, ack, index; second: commit
// - code 00000 does nothing and the data bus is ignored
// - code 00001 is a fill that reports an I/O or missing-memory error
// - code 00100 reports ownership granted, no data moves
// - code 00101 reports ownership denied, no data moves
// - code 00110 reports the pending memory barrier has completed
// - code 00111 only says the release and index fields are valid
// - codes 100xx fill clean, low bits give wrap order
// - codes 101xx fill owned (dirty), low bits give wrap order
// - codes 110xx fill clean shared, low bits give wrap order
// - codes 111xx fill shared owned, low bits give wrap order
// - codes 010xx make the device drive write data, wrapped by octaword
// - ack bit set decrements the outstanding-command counter, any code
// - a probe's carried code takes effect only after the probe
// - data-valid strobes are checked every data cycle; high means gap
// - commit bit decrements the uncommitted-event counter
// - releases clear buffer valid by index; probe slot uses low bits
// - top command line in the first cycle: one probe, zero data-move
module dmc_decode (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// command link pins
	input wire logic sys_cmd_clk,
	input wire logic [dmc_pkg::CMD_W-1:0] sys_cmd_in_n,
	input wire logic inbound_word_valid_n,
	input wire logic outbound_word_valid_n,
	// shared data bus pins
	input wire logic [dmc_pkg::DATA_W-1:0] shared_data_bus_i,
	output logic [dmc_pkg::DATA_W-1:0] shared_data_bus_o,
	output logic shared_data_bus_oe,
	// core side
	input wire logic cmd_issued,
	input wire logic event_recorded,
	input wire logic [dmc_pkg::DATA_W-1:0] drain_word,
	output dmc_pkg::dmc_evt_t evt_q,
	output logic [2:0] drain_word_idx_q,
	output logic [dmc_pkg::DATA_W-1:0] fill_word_q,
	output logic [2:0] fill_word_idx_q,
	output logic fill_word_vld_q
);
	typedef enum logic [2:0] {
		PS_FIRST,
		PS_DM2,
		PS_PR2,
		PS_PR3,
		PS_PR4
	} dmc_parse_t;

	// quadword index: start at the chosen octaword, wrap within the block
	function automatic logic [2:0] qw_index(input logic [1:0] wrap,
		input logic [3:0] beat);
		logic [2:0] start;
		start = {wrap, 1'b0};
		return start + beat[2:0];
	endfunction

	// synchronised pins
	logic [dmc_pkg::CMD_W+2:0] pins_s;
	logic [dmc_pkg::DATA_W-1:0] data_s;
	dmc_sync2 #(.W(dmc_pkg::CMD_W + 3)) u_sync_cmd (
		.clk(clk),
		.rst_n(rst_n),
		.d({sys_cmd_clk, inbound_word_valid_n, outbound_word_valid_n,
			sys_cmd_in_n}),
		.q(pins_s)
	);
	dmc_sync2 #(.W(dmc_pkg::DATA_W)) u_sync_data (
		.clk(clk),
		.rst_n(rst_n),
		.d(shared_data_bus_i),
		.q(data_s)
	);

	wire logic lclk_s = pins_s[dmc_pkg::CMD_W+2];
	wire logic in_valid_n_s = pins_s[dmc_pkg::CMD_W+1];
	wire logic out_valid_n_s = pins_s[dmc_pkg::CMD_W];
	// command pins are active low
	wire logic [dmc_pkg::CMD_W-1:0] word = ~pins_s[dmc_pkg::CMD_W-1:0];

	// state
	logic lclk_q;
	dmc_parse_t st_q;
	logic [dmc_pkg::CMD_W-1:0] c1_q;
	logic pend_q;
	logic pcommit_q;
	logic [2:0] ctrl_q;
	logic wb_ack_q;
	logic err_q;
	logic ph_fill_q;
	logic ph_drain_q;
	logic [3:0] beat_q;
	logic [1:0] wrap_q;
	logic [dmc_pkg::CNT_W-1:0] out_cnt;
	logic [dmc_pkg::CNT_W-1:0] unc_cnt;
	dmc_pkg::dmc_evt_t evt_d;

	wire logic enabled = ctrl_q[dmc_pkg::CTRL_EN];
	wire logic link_edge = lclk_s & ~lclk_q & enabled;

	// command dispatch
	wire logic fire_now = link_edge && st_q == PS_DM2;
	wire logic go = fire_now | pend_q;
	wire logic [4:0] code = c1_q[dmc_pkg::B_CODE_HI:dmc_pkg::B_CODE_LO];
	wire logic [2:0] cls = code[4:2];
	wire logic commit = fire_now ? word[dmc_pkg::B_COMMIT] : pcommit_q;
	wire logic is_err = code == dmc_pkg::DC_FILL_ERR;
	wire logic is_fill = cls[2] | is_err;
	wire logic is_drain = cls == dmc_pkg::CLS_DRAIN;
	wire logic fill_cmd = go & is_fill;
	wire logic drain_cmd = go & is_drain;

	// parse the command stream one link cycle at a time
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lclk_q <= 1'b0;
			st_q <= PS_FIRST;
			c1_q <= '0;
			pend_q <= 1'b0;
			pcommit_q <= 1'b0;
		end else begin
			lclk_q <= lclk_s;
			pend_q <= 1'b0;
			if (link_edge) begin
				case (st_q)
				PS_FIRST: begin
					if (word[dmc_pkg::B_TYPE]) begin
						st_q <= PS_PR2;
					end else begin
						c1_q <= word;
						st_q <= PS_DM2;
					end
				end
				PS_DM2: st_q <= PS_FIRST;
				PS_PR2: st_q <= PS_PR3;
				PS_PR3: begin
					c1_q <= word;
					st_q <= PS_PR4;
				end
				PS_PR4: begin
					// carried code waits one cycle behind the probe
					pend_q <= 1'b1;
					pcommit_q <= word[dmc_pkg::B_COMMIT];
					st_q <= PS_FIRST;
				end
				default: st_q <= PS_FIRST;
				endcase
			end
		end
	end

	// event pulses for the core
	always_comb begin
		evt_d = '0;
		evt_d.probe_seen = link_edge && st_q == PS_PR4;
		if (go) begin
			// nop and unassigned codes fall through with no data action
			evt_d.fill_go = is_fill;
			evt_d.fill_error = is_err;
			evt_d.wrap = code[1:0];
			case (cls)
			dmc_pkg::CLS_OWNED: evt_d.fill_state = dmc_pkg::FS_OWNED;
			dmc_pkg::CLS_SHARED: begin
				evt_d.fill_state = dmc_pkg::FS_CLEAN_SHARED;
			end
			dmc_pkg::CLS_SH_OWNED: begin
				evt_d.fill_state = dmc_pkg::FS_SHARED_OWNED;
			end
			default: evt_d.fill_state = dmc_pkg::FS_CLEAN;
			endcase
			evt_d.ownership_granted = code == dmc_pkg::DC_OWN_OK;
			evt_d.ownership_denied = code == dmc_pkg::DC_OWN_FAIL;
			evt_d.barrier_complete = code == dmc_pkg::DC_BARRIER;
			evt_d.drain_write = is_drain;
			// probe-carried commands have no victim release field
			evt_d.release_victim_buf = c1_q[dmc_pkg::B_RVB] & ~pend_q;
			evt_d.victim_idx = c1_q[dmc_pkg::B_ID_HI:dmc_pkg::B_ID_LO];
			evt_d.release_probe_slot = c1_q[dmc_pkg::B_RPB];
			evt_d.probe_idx = c1_q[dmc_pkg::B_ID_LO+2:dmc_pkg::B_ID_LO];
			evt_d.ack_seen = c1_q[dmc_pkg::B_ACK];
			evt_d.commit_seen = commit;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			evt_q <= '0;
		end else begin
			evt_q <= evt_d;
		end
	end

	// data phase: fills sample the bus, drains drive it
	wire logic beats_done = beat_q == dmc_pkg::FILL_BEATS;
	wire logic fill_take = link_edge & ph_fill_q & ~in_valid_n_s & ~beats_done;
	wire logic drain_give = link_edge & ph_drain_q & ~out_valid_n_s &
		~beats_done;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_fill_q <= 1'b0;
			ph_drain_q <= 1'b0;
			beat_q <= '0;
			wrap_q <= '0;
		end else if (fill_cmd | drain_cmd) begin
			// a newer fill or drain command overrides whatever phase is running
			ph_fill_q <= fill_cmd;
			ph_drain_q <= drain_cmd;
			beat_q <= '0;
			wrap_q <= code[1:0];
		end else if (link_edge & beats_done) begin
			ph_fill_q <= 1'b0;
			ph_drain_q <= 1'b0;
		end else if (fill_take | drain_give) begin
			// a high strobe is a gap: no beat is counted for it
			beat_q <= beat_q + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fill_word_q <= '0;
			fill_word_idx_q <= '0;
			fill_word_vld_q <= 1'b0;
			shared_data_bus_o <= '0;
			drain_word_idx_q <= '0;
		end else begin
			fill_word_vld_q <= fill_take;
			drain_word_idx_q <= qw_index(wrap_q, beat_q);
			if (fill_take) begin
				fill_word_q <= data_s;
				fill_word_idx_q <= qw_index(wrap_q, beat_q);
			end
			if (drain_give) begin
				shared_data_bus_o <= drain_word;
			end
		end
	end

	assign shared_data_bus_oe = ph_drain_q;

	// bookkeeping counters
	wire logic wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_q;
	wire logic wb_wr = wb_req & wb_we_i;
	wire logic hit_ctrl = wb_adr_i == dmc_pkg::REG_CTRL;
	wire logic hit_status = wb_adr_i == dmc_pkg::REG_STATUS;
	wire logic hit_last = wb_adr_i == dmc_pkg::REG_LAST;
	wire logic ctrl_wr = wb_wr & hit_ctrl & wb_sel_i[0];
	wire logic clr_out = ctrl_wr & wb_dat_i[dmc_pkg::CTRL_CLR_OUT];
	wire logic clr_unc = ctrl_wr & wb_dat_i[dmc_pkg::CTRL_CLR_UNC];
	wire logic err_clr = wb_wr & hit_last & wb_sel_i[2] &
		wb_dat_i[dmc_pkg::LAST_ERR];

	dmc_updown u_outstanding (
		.clk(clk),
		.rst_n(rst_n),
		.clr(clr_out),
		.inc(cmd_issued),
		.dec(evt_d.ack_seen),
		.count_q(out_cnt)
	);
	dmc_updown u_uncommitted (
		.clk(clk),
		.rst_n(rst_n),
		.clr(clr_unc),
		.inc(event_recorded),
		.dec(evt_d.commit_seen),
		.count_q(unc_cnt)
	);

	// register read mux
	logic [31:0] status_w;
	logic [31:0] last_w;
	always_comb begin
		status_w = '0;
		status_w[dmc_pkg::CNT_W-1:0] = out_cnt;
		status_w[dmc_pkg::ST_UNC_LO+:dmc_pkg::CNT_W] = unc_cnt;
		status_w[dmc_pkg::ST_FILL] = ph_fill_q;
		status_w[dmc_pkg::ST_DRAIN] = ph_drain_q;
		status_w[dmc_pkg::ST_PROBE] = st_q == PS_PR2 || st_q == PS_PR3 ||
			st_q == PS_PR4 || pend_q;
		last_w = '0;
		last_w[4:0] = code;
		last_w[dmc_pkg::LAST_ID_LO+:4] =
			c1_q[dmc_pkg::B_ID_HI:dmc_pkg::B_ID_LO];
		last_w[dmc_pkg::LAST_ERR] = err_q;
	end

	wire logic [31:0] rd_data = hit_ctrl ? {29'h0, ctrl_q} :
		hit_status ? status_w :
		hit_last ? last_w : 32'h0;

	// wishbone: answer one cycle after the request, unmapped reads zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_q <= 1'b0;
			wb_dat_o <= '0;
			ctrl_q <= dmc_pkg::CTRL_RST;
			err_q <= 1'b0;
		end else begin
			wb_ack_q <= wb_req;
			if (wb_req) begin
				wb_dat_o <= rd_data;
			end
			if (ctrl_wr) begin
				ctrl_q <= {2'b00, wb_dat_i[dmc_pkg::CTRL_EN]};
			end
			// a new error wins over a clear in the same cycle
			if (go & is_err) begin
				err_q <= 1'b1;
			end else if (err_clr) begin
				err_q <= 1'b0;
			end
		end
	end

	assign wb_ack_o = wb_ack_q;
endmodule
`default_nettype wire

// *** dmc_pkg.sv ***
// constants, field layout and event carrier for the data-move decoder
// assumes a single 40 MHz core clock; used by dmc_decode, dmc_updown, the monitor and the bench
package dmc_pkg;

	// widths
	localparam int CMD_W = 15;
	localparam int DATA_W = 64;
	localparam int CNT_W = 5;
	localparam int BEAT_W = 4;
	localparam logic [3:0] FILL_BEATS = 4'h8;

	// first-cycle field positions (logical, after pin inversion)
	localparam int B_TYPE = 14;
	localparam int B_CODE_HI = 13;
	localparam int B_CODE_LO = 9;
	localparam int B_RVB = 8;
	localparam int B_RPB = 7;
	localparam int B_ACK = 6;
	localparam int B_ID_HI = 5;
	localparam int B_ID_LO = 2;
	// second-cycle field position
	localparam int B_COMMIT = 14;

	// data-move codes and code classes (top three bits)
	localparam logic [4:0] DC_NOP = 5'h00;
	localparam logic [4:0] DC_FILL_ERR = 5'h01;
	localparam logic [4:0] DC_OWN_OK = 5'h04;
	localparam logic [4:0] DC_OWN_FAIL = 5'h05;
	localparam logic [4:0] DC_BARRIER = 5'h06;
	localparam logic [4:0] DC_FREE = 5'h07;
	localparam logic [2:0] CLS_DRAIN = 3'h2;
	localparam logic [2:0] CLS_CLEAN = 3'h4;
	localparam logic [2:0] CLS_OWNED = 3'h5;
	localparam logic [2:0] CLS_SHARED = 3'h6;
	localparam logic [2:0] CLS_SH_OWNED = 3'h7;

	// register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_LAST = 8'h08;
	localparam logic [2:0] CTRL_RST = 3'h1;
	localparam int CTRL_EN = 0;
	localparam int CTRL_CLR_OUT = 1;
	localparam int CTRL_CLR_UNC = 2;
	localparam int ST_UNC_LO = 8;
	localparam int ST_FILL = 16;
	localparam int ST_DRAIN = 17;
	localparam int ST_PROBE = 18;
	localparam int LAST_ID_LO = 8;
	localparam int LAST_ERR = 16;

	typedef enum logic [1:0] {
		FS_CLEAN,
		FS_OWNED,
		FS_CLEAN_SHARED,
		FS_SHARED_OWNED
	} dmc_fill_state_t;

	typedef struct packed {
		logic fill_go;
		logic fill_error;
		dmc_fill_state_t fill_state;
		logic [1:0] wrap;
		logic ownership_granted;
		logic ownership_denied;
		logic barrier_complete;
		logic drain_write;
		logic release_victim_buf;
		logic [3:0] victim_idx;
		logic release_probe_slot;
		logic [2:0] probe_idx;
		logic probe_seen;
		logic ack_seen;
		logic commit_seen;
	} dmc_evt_t;

endpackage

// *** dmc_sync2.sv ***
// two-flop synchroniser for levels arriving from outside the clock domain
// assumes the sender holds each value for several core clocks
`timescale 1ns/1ps
`default_nettype none
module dmc_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	// the first stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
`default_nettype wire

// *** dmc_updown.sv ***
// saturating up/down counter for credit style bookkeeping
// assumes inc and dec are single-cycle pulses on clk
`timescale 1ns/1ps
`default_nettype none
module dmc_updown (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic clr,
	input wire logic inc,
	input wire logic dec,
	output logic [dmc_pkg::CNT_W-1:0] count_q
);
	logic [dmc_pkg::CNT_W-1:0] count_d;
	wire logic at_max = &count_q;
	wire logic at_min = ~|count_q;

	// saturate rather than wrap: a stray ack must not fake credits
	always_comb begin
		count_d = count_q;
		if (clr) begin
			count_d = '0;
		end else if (inc && !dec && !at_max) begin
			count_d = count_q + 1'b1;
		end else if (dec && !inc && !at_min) begin
			count_d = count_q - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end
endmodule
`default_nettype wire

// *** dmc_decode_monitor.sv ***
// port-level assertions for the data-move decoder
// assumes one clock domain with an async active-low reset
`timescale 1ns/1ps
`default_nettype none
module dmc_decode_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// watched ports
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire dmc_pkg::dmc_evt_t evt_q,
	input wire logic shared_data_bus_oe,
	input wire logic fill_word_vld_q
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_own_exclusive: assert property (
		!(evt_q.ownership_granted && evt_q.ownership_denied))
		else $error("ownership granted and denied together");
	a_state_needs_fill: assert property (
		evt_q.fill_state != dmc_pkg::FS_CLEAN |-> evt_q.fill_go)
		else $error("fill state without fill");
	a_error_alone: assert property (
		evt_q.fill_error |-> !(evt_q.ownership_granted ||
		evt_q.barrier_complete || evt_q.drain_write))
		else $error("fill error mixed with other code");
	a_drain_drives: assert property (
		evt_q.drain_write |-> ##[0:1] shared_data_bus_oe)
		else $error("drain without bus drive");
	a_oe_cause: assert property (
		$rose(shared_data_bus_oe) |->
		evt_q.drain_write || $past(evt_q.drain_write))
		else $error("bus driven without drain");
	a_fill_undriven: assert property (
		fill_word_vld_q |-> !shared_data_bus_oe)
		else $error("fill beat while driving bus");
	a_barrier_pulse: assert property (
		evt_q.barrier_complete |=> !evt_q.barrier_complete)
		else $error("barrier event too long");
	a_probe_first: assert property (
		evt_q.probe_seen |-> !evt_q.barrier_complete)
		else $error("barrier not after probe");
	a_wb_answer: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus access not answered");
	c_fill: cover property (evt_q.fill_go && evt_q.fill_state == 2'h3);
	c_probe: cover property (evt_q.probe_seen);
	c_drain_end: cover property ($fell(shared_data_bus_oe));
endmodule
bind dmc_decode dmc_decode_monitor u_mon (.clk(clk), .rst_n(rst_n),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.evt_q(evt_q), .shared_data_bus_oe(shared_data_bus_oe),
	.fill_word_vld_q(fill_word_vld_q));
`default_nettype wire

// *** dmc_sys_model.sv ***
// system-side model: link clock, command words, data beats
// assumes clk is the 25 ns core clock; one link cycle is 8 clk
`timescale 1ns/1ps
`default_nettype none
module dmc_sys_model (
	// clock
	input wire logic clk,
	// link side
	output logic lk_clk,
	output logic [14:0] cmd_n,
	output logic vld_n,
	output logic [63:0] data
);
	initial begin
		lk_clk = 1'b0;
		cmd_n = '1;
		vld_n = 1'b1;
		data = '0;
	end
	// link clock runs only in frames; a released bus shows inverted data
	task automatic link(input logic [14:0] w, input logic v,
		input logic [63:0] d);
		cmd_n <= ~w;
		vld_n <= ~v;
		data <= v ? d : ~data;
		repeat (4) @(posedge clk);
		lk_clk <= 1'b1;
		repeat (4) @(posedge clk);
		lk_clk <= 1'b0;
	endtask
	// even link count keeps idle nop pairs aligned after the data phase
	task automatic send(input logic [59:0] w, input int nw, input int nb,
		input int gap, input logic [63:0] base);
		int j;
		j = 0;
		for (int i = 0; i < nw; i++)
			link(w[59-15*i-:15], 1'b0, 64'h0);
		for (int k = 0; k < nb; k++) begin
			link(15'h0, k != gap && j < 8, base + 64'(j));
			j += int'(k != gap && j < 8);
		end
		cmd_n <= '1;
		vld_n <= 1'b1;
		data <= ~data;
	endtask
endmodule
`default_nettype wire

// *** dmc_decode_tb_top.sv ***
// self-checking bench for the data-move decoder
// assumes the system model drives the link and wishbone runs on clk
`timescale 1ns/1ps
`default_nettype none
module dmc_decode_tb_top;
	logic clk, rst_n, cyc, stb, we, ack, oe, fvld, ci, er, lk, vn, clr;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, v, seed;
	logic [63:0] di, dout, dw, fw, base;
	logic [2:0] didx, fidx;
	logic [1:0] wr;
	logic [14:0] cn;
	dmc_pkg::dmc_evt_t evt, acc;
	int errors, checks_done, out, unc, bc;
	dmc_decode dut (
		.clk(clk),
		.rst_n(rst_n),
		.wb_cyc_i(cyc),
		.wb_stb_i(stb),
		.wb_we_i(we),
		.wb_adr_i(adr),
		.wb_sel_i(4'hF),
		.wb_dat_i(wdat),
		.wb_dat_o(rdat),
		.wb_ack_o(ack),
		.sys_cmd_clk(lk),
		.sys_cmd_in_n(cn),
		.inbound_word_valid_n(vn),
		.outbound_word_valid_n(vn),
		.shared_data_bus_i(di),
		.shared_data_bus_o(dout),
		.shared_data_bus_oe(oe),
		.cmd_issued(ci),
		.event_recorded(er),
		.drain_word(dw),
		.evt_q(evt),
		.drain_word_idx_q(didx),
		.fill_word_q(fw),
		.fill_word_idx_q(fidx),
		.fill_word_vld_q(fvld)
	);
	dmc_sys_model pm (.clk(clk), .lk_clk(lk), .cmd_n(cn), .vld_n(vn),
		.data(di));
	assign dw = {16{1'b0, didx}};
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk_v(input logic [63:0] g, input logic [63:0] e);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic dmc_pkg::dmc_evt_t ex(input logic [14:0] a,
		input logic c, input logic p);
		dmc_pkg::dmc_evt_t e;
		logic [4:0] k;
		k = a[13:9];
		e = '0;
		e.fill_go = k[4] || k == dmc_pkg::DC_FILL_ERR;
		e.fill_error = k == dmc_pkg::DC_FILL_ERR;
		if (k[4])
			e.fill_state = dmc_pkg::dmc_fill_state_t'(k[3:2]);
		e.wrap = k[1:0];
		e.ownership_granted = k == dmc_pkg::DC_OWN_OK;
		e.ownership_denied = k == dmc_pkg::DC_OWN_FAIL;
		e.barrier_complete = k == dmc_pkg::DC_BARRIER;
		e.drain_write = k[4:2] == dmc_pkg::CLS_DRAIN;
		e.release_victim_buf = a[8];
		e.victim_idx = a[5:2];
		e.release_probe_slot = a[7];
		e.probe_idx = a[4:2];
		e.probe_seen = p;
		e.ack_seen = a[6];
		e.commit_seen = c;
		return e;
	endfunction
	// wrap and indexes are only meaningful where their code or bit says so
	function automatic dmc_pkg::dmc_evt_t mk(input logic [14:0] a);
		dmc_pkg::dmc_evt_t m;
		m = '1;
		if (!a[13] && a[13:11] != dmc_pkg::CLS_DRAIN)
			m.wrap = 2'h0;
		if (!a[8])
			m.victim_idx = 4'h0;
		if (!a[7])
			m.probe_idx = 3'h0;
		return m;
	endfunction
	task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= ad;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		v = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) begin
			errors++;
			summarize();
		end
		@(posedge clk);
	endtask
	task automatic cmd(input logic [4:0] k, input logic p, input int nb,
		input int gap);
		logic [31:0] r;
		logic [14:0] a;
		logic c;
		int n;
		r = rnd();
		a = {1'b0, k, r[8] & ~p, r[7:2], 2'h0};
		c = r[9] | ~r[6];
		ci <= r[10];
		er <= r[11];
		clr <= 1'b1;
		@(posedge clk);
		ci <= 1'b0;
		er <= 1'b0;
		clr <= 1'b0;
		out += int'(r[10] && out < 31);
		unc += int'(r[11] && unc < 31);
		wr = k[1:0];
		bc = 0;
		base = {r, rnd()};
		if (p)
			pm.send({1'b1, r[27:14], r[29:15], a, c, 14'h0}, 4, nb, gap, base);
		else
			pm.send({a, c, 14'h0, 30'h0}, 2, nb, gap, base);
		n = 0;
		while (!(acc.ack_seen || acc.commit_seen) && n < 40) begin
			@(posedge clk);
			n++;
		end
		if (!(acc.ack_seen || acc.commit_seen)) begin
			errors++;
			summarize();
		end
		chk_v(64'(acc & mk(a)), 64'(ex(a, c, p) & mk(a)));
		out -= int'(a[6] && out > 0);
		unc -= int'(c && unc > 0);
		wb(1'b0, dmc_pkg::REG_STATUS, 32'h0);
		chk_v(64'(v[4:0]), 64'(out));
		chk_v(64'(v[12:8]), 64'(unc));
	endtask
	always @(posedge clk) begin
		acc <= clr ? '0 : acc | evt;
		if (fvld === 1'b1) begin
			chk_v(fw, base + 64'(bc));
			chk_v(64'(fidx), 64'(3'(2 * wr + bc)));
			bc = bc + 1;
		end
	end
	initial begin
		seed = 32'h000054E6;
		{rst_n, cyc, stb, we, ci, er, clr} = '0;
		adr = 8'h00;
		wdat = 32'h0;
		acc = '0;
		{errors, checks_done, out, unc, bc} = '0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		wb(1'b0, dmc_pkg::REG_CTRL, 32'h0);
		chk_v(64'(v), 64'(dmc_pkg::CTRL_RST));
		wb(1'b0, 8'h0C, 32'h0);
		chk_v(64'(v), 64'h0);
		for (int i = 0; i < 32; i++) begin
			cmd(5'(i), 1'b0, 0, 0);
			if (i > 15 || i / 4 == 2 || i == 1)
				repeat (4) cmd(5'h00, 1'b0, 0, 0);
		end
		// the error fill above must have left the sticky flag set
		wb(1'b0, dmc_pkg::REG_LAST, 32'h0);
		chk_v(64'(v[dmc_pkg::LAST_ERR]), 64'h1);
		wb(1'b1, dmc_pkg::REG_LAST, 32'h00010000);
		wb(1'b0, dmc_pkg::REG_LAST, 32'h0);
		chk_v(64'(v[dmc_pkg::LAST_ERR]), 64'h0);
		// both counter clears at once, link stays enabled
		wb(1'b1, dmc_pkg::REG_CTRL, 32'h00000007);
		out = 0;
		unc = 0;
		wb(1'b0, dmc_pkg::REG_STATUS, 32'h0);
		chk_v(64'(v[12:0]), 64'h0);
		for (int i = 0; i < 4; i++) begin
			cmd({1'b1, 2'(i), 2'(rnd())}, 1'b0, 10, 3);
			chk_v(64'(bc), 64'h8);
		end
		cmd({3'h2, 2'(rnd())}, 1'b0, 10, 8);
		chk_v(64'(oe), 64'h0);
		chk_v(dout, {16{1'b0, 3'(2 * wr + 7)}});
		cmd(dmc_pkg::DC_BARRIER, 1'b1, 0, 0);
		wb(1'b1, dmc_pkg::REG_CTRL, 32'h0);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		pm.send({15'h0040, 15'h4000, 30'h0}, 2, 0, 0, 64'h0);
		repeat (8) @(posedge clk);
		chk_v(64'(acc), 64'h0);
		wb(1'b1, dmc_pkg::REG_CTRL, 32'h1);
		cmd(dmc_pkg::DC_FREE, 1'b0, 0, 0);
		summarize();
	end
endmodule
`default_nettype wire
